// ---- rtl/cid_pkg.sv ----
// shared constants and carriers for the interrupt dispatch engine
package cid_pkg;
  // register byte offsets
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_PRIV = 8'h04;
  localparam logic [7:0] A_CTP = 8'h08;
  localparam logic [7:0] A_BTP = 8'h0c;
  localparam logic [7:0] A_GP1 = 8'h10;
  localparam logic [7:0] A_GP2 = 8'h14;
  localparam logic [7:0] A_GP3 = 8'h18;
  localparam logic [7:0] A_IP = 8'h1c;
  localparam logic [7:0] A_CMD = 8'h20;
  localparam logic [7:0] A_FAULT = 8'h24;
  localparam logic [7:0] A_STATE = 8'h28;
  localparam logic [7:0] A_HND = 8'h2c;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // status word and vector flag bits
  localparam int ST_HW_EN = 0;
  localparam int ST_TSK_EN = 2;
  localparam int VF_PRIV = 0;
  // fault flag masks
  localparam logic [31:0] FF_PRIV_M = 32'h0000_0001;
  localparam logic [31:0] FF_PERM_M = 32'h0000_0002;
  localparam logic [31:0] FF_BADV_M = 32'h0000_0004;
  localparam logic [31:0] FF_SOFT_INTERRUPT_INSTR_M = 32'h0000_2000;
  // command word: op in [9:8], id in [6:0]
  localparam int CMD_OP_LSB = 8;
  localparam logic [1:0] OP_TASK_LOAD = 2'h1;
  localparam logic [1:0] OP_SOFT_INT = 2'h2;
  // interrupt ids
  localparam logic [6:0] VEC_ENTRIES = 7'h7f;
  localparam logic [6:0] ID_VEC_CFG = 7'h01;
  localparam logic [6:0] ID_KBD = 7'h09;
  localparam logic [6:0] ID_TIMER = 7'h10;
  localparam logic [6:0] ID_IMPL_LO = 7'h15;
  localparam logic [6:0] ID_USER_LO = 7'h20;
  // vector table and task structure layout
  localparam logic [31:0] VEC_BASE = 32'h0000_0000;
  localparam logic [31:0] VEC_STRIDE = 32'h0000_0008;
  localparam logic [31:0] VEC_ADDR_OFS = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [2:0] CTX_LAST = 3'h4;
  // carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cid_mem_req_t;
  typedef struct packed {
    logic valid;
    logic [6:0] id;
  } cid_int_evt_t;
endpackage

// ---- rtl/cid_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cid_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin side
  input wire logic [W-1:0] d,
  // clock side
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r, s2_r, s3_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // cid_sync
`default_nettype wire

// ---- rtl/cid_dispatch.sv ----
// interrupt dispatch and task switch engine with ahb-lite registers
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - task load saves to base, loads current
// - task load above level 0 faults
// - task load idle when switching disabled
// - software interrupts ignore hardware mask bit
// - soft interrupt switches to handler at once
// - interrupt saves to current, loads base
// - ip holds instruction until checks pass
// - hardware interrupt waits for instruction end
// - internal routine runs before configured handler
// - 127 entries of flags and address
// - flag bit 0 gives allowed privilege
// - soft interrupt at level 1 on level-0 entry faults
// - ids below 32 are architecture ones
// - non-trappable ids skip their entry
// - table fixed at address zero
// - id 1 writes entry from gp1-3
// - id 1 above level 0 faults
// - id 1 with bad id faults
// - interrupt fault stores id, sets bit 13
module cid_dispatch (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pipeline
  input wire logic instr_active,
  // device interrupt pins
  input wire logic hw_irq_req,
  input wire logic [6:0] hw_irq_id,
  // memory port
  output var cid_pkg::cid_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // internal routine
  output var cid_pkg::cid_int_evt_t int_start,
  input wire logic int_done
);
  typedef enum {S_IDLE, S_CHECK, S_INT_RUN, S_VEC_FLAG, S_VEC_ADDR,
    S_CFG_FLAG, S_CFG_ADDR, S_SAVE, S_LOAD, S_FINISH} cid_state_t;

  cid_state_t state_r, state_nxt;
  logic [31:0] status_r, ctp_r, btp_r, gp1_r, gp2_r, gp3_r, ip_r;
  logic [31:0] fault_r, handler_r, vflag_r, rd_c;
  logic priv_r, is_hw_r, is_task_r, irq_pend_r, irq_q_d;
  logic [6:0] id_r;
  logic [2:0] ctx_idx_r;
  logic ap_wr_r;
  logic [7:0] ap_addr_r;
  logic [7:0] irq_q;
  logic [1:0] cmd_op;
  logic ap_take, wr_go, cmd_go, hw_go, idle, acc_done, last_word;
  logic trap, ld_handler, mem_st, wr_c;
  logic [31:0] fault_set, soft_interrupt_instr_f, mem_addr_c, wdata_c, ctx_out, hnd_c;
  logic [31:0] vec_a, cfg_a, sv_base, ld_base;

  function automatic logic trappable(input logic [6:0] i);
    trappable = (i >= cid_pkg::ID_IMPL_LO) || (i == cid_pkg::ID_KBD) ||
      (i == cid_pkg::ID_TIMER);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser
  cid_sync #(.W(8)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({hw_irq_req, hw_irq_id}),
    .q(irq_q)
  );

  ////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  assign ap_take = hsel && htrans[1] && hready &&
    (hsize == cid_pkg::HSIZE_WORD) && (haddr[31:8] == 24'h000000);
  assign wr_go = ap_wr_r;
  assign idle = (state_r == S_IDLE);
  assign cmd_op = hwdata[cid_pkg::CMD_OP_LSB +: 2];
  assign cmd_go = wr_go && idle && (ap_addr_r == cid_pkg::A_CMD) &&
    ((cmd_op == cid_pkg::OP_TASK_LOAD) || (cmd_op == cid_pkg::OP_SOFT_INT));

  always_comb begin
    rd_c = 32'h0;
    case (haddr[7:0])
      cid_pkg::A_STATUS: rd_c = status_r;
      cid_pkg::A_PRIV: rd_c = {31'h0, priv_r};
      cid_pkg::A_CTP: rd_c = ctp_r;
      cid_pkg::A_BTP: rd_c = btp_r;
      cid_pkg::A_GP1: rd_c = gp1_r;
      cid_pkg::A_GP2: rd_c = gp2_r;
      cid_pkg::A_GP3: rd_c = gp3_r;
      cid_pkg::A_IP: rd_c = ip_r;
      cid_pkg::A_FAULT: rd_c = fault_r;
      cid_pkg::A_STATE: rd_c = {24'h0, id_r, !idle};
      cid_pkg::A_HND: rd_c = handler_r;
      default: rd_c = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata <= cid_pkg::REG_RST;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_wr_r <= ap_take && hwrite;
      ap_addr_r <= haddr[7:0];
      hrdata <= (ap_take && !hwrite) ? rd_c : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // privilege and task pointers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      priv_r <= 1'b0;
      ctp_r <= cid_pkg::REG_RST;
      btp_r <= cid_pkg::REG_RST;
    end else if (wr_go && idle) begin
      if (ap_addr_r == cid_pkg::A_PRIV) begin
        priv_r <= hwdata[0];
      end
      if (ap_addr_r == cid_pkg::A_CTP) begin
        ctp_r <= hwdata;
      end
      if (ap_addr_r == cid_pkg::A_BTP) begin
        btp_r <= hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // context registers
  assign hnd_c = (state_r == S_VEC_ADDR) ? mem_rdata : handler_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= cid_pkg::REG_RST;
      gp1_r <= cid_pkg::REG_RST;
      gp2_r <= cid_pkg::REG_RST;
      gp3_r <= cid_pkg::REG_RST;
      ip_r <= cid_pkg::REG_RST;
    end else begin
      if (wr_go && idle) begin
        case (ap_addr_r)
          cid_pkg::A_STATUS: status_r <= hwdata;
          cid_pkg::A_GP1: gp1_r <= hwdata;
          cid_pkg::A_GP2: gp2_r <= hwdata;
          cid_pkg::A_GP3: gp3_r <= hwdata;
          cid_pkg::A_IP: ip_r <= hwdata;
          default: ;
        endcase
      end
      if (state_r == S_LOAD && acc_done) begin
        case (ctx_idx_r)
          3'h0: ip_r <= mem_rdata;
          3'h1: status_r <= mem_rdata;
          3'h2: gp1_r <= mem_rdata;
          3'h3: gp2_r <= mem_rdata;
          default: gp3_r <= mem_rdata;
        endcase
      end
      if (ld_handler) begin
        ip_r <= hnd_c;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fault flags word
  assign soft_interrupt_instr_f = {1'b0, id_r, 24'h0} | cid_pkg::FF_SOFT_INTERRUPT_INSTR_M;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_r <= cid_pkg::REG_RST;
    end else if (wr_go && ap_addr_r == cid_pkg::A_FAULT) begin
      fault_r <= hwdata | fault_set;
    end else begin
      fault_r <= fault_r | fault_set;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // request capture
  // soft path has no mask
  assign hw_go = idle && irq_pend_r && status_r[cid_pkg::ST_HW_EN] &&
    !instr_active && !cmd_go;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q_d <= 1'b0;
      irq_pend_r <= 1'b0;
      id_r <= 7'h00;
      is_task_r <= 1'b0;
      is_hw_r <= 1'b0;
    end else begin
      irq_q_d <= irq_q[7];
      irq_pend_r <= (irq_q[7] && !irq_q_d) || (irq_pend_r && !hw_go);
      if (cmd_go) begin
        id_r <= hwdata[6:0];
        is_task_r <= (cmd_op == cid_pkg::OP_TASK_LOAD);
        is_hw_r <= 1'b0;
      end else if (hw_go) begin
        id_r <= irq_q[6:0];
        is_task_r <= 1'b0;
        is_hw_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dispatch state machine
  assign trap = trappable(id_r);
  assign last_word = (ctx_idx_r == cid_pkg::CTX_LAST);

  always_comb begin
    state_nxt = state_r;
    fault_set = 32'h0;
    ld_handler = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (cmd_go || hw_go) begin
          state_nxt = S_CHECK;
        end
      end
      S_CHECK: begin
        if (is_task_r) begin
          if (priv_r) begin
            fault_set = cid_pkg::FF_PRIV_M;
            state_nxt = S_FINISH;
          end else if (!status_r[cid_pkg::ST_TSK_EN]) begin
            state_nxt = S_FINISH;
          end else begin
            state_nxt = S_SAVE;
          end
        end else if (id_r == cid_pkg::ID_VEC_CFG && !is_hw_r) begin
          if (priv_r) begin
            fault_set = soft_interrupt_instr_f | cid_pkg::FF_PERM_M;
            state_nxt = S_FINISH;
          end else if (gp1_r >= 32'(cid_pkg::VEC_ENTRIES) ||
              !trappable(gp1_r[6:0])) begin
            fault_set = soft_interrupt_instr_f | cid_pkg::FF_BADV_M;
            state_nxt = S_FINISH;
          end else begin
            state_nxt = S_CFG_FLAG;
          end
        end else if (id_r >= cid_pkg::VEC_ENTRIES) begin
          fault_set = soft_interrupt_instr_f | cid_pkg::FF_BADV_M;
          state_nxt = S_FINISH;
        end else if (id_r < cid_pkg::ID_USER_LO) begin
          state_nxt = S_INT_RUN;
        end else begin
          state_nxt = S_VEC_FLAG;
        end
      end
      S_INT_RUN: begin
        if (int_done) begin
          state_nxt = trap ? S_VEC_FLAG : S_FINISH;
        end
      end
      S_VEC_FLAG: begin
        if (acc_done) begin
          state_nxt = S_VEC_ADDR;
        end
      end
      S_VEC_ADDR: begin
        if (acc_done) begin
          state_nxt = S_FINISH;
          if (vflag_r == 32'h0 && mem_rdata == 32'h0) begin
            state_nxt = S_FINISH;
          end else if (!is_hw_r && priv_r && !vflag_r[cid_pkg::VF_PRIV]) begin
            fault_set = soft_interrupt_instr_f | cid_pkg::FF_PRIV_M;
          end else if (status_r[cid_pkg::ST_TSK_EN]) begin
            state_nxt = S_SAVE;
          end else begin
            ld_handler = 1'b1;
          end
        end
      end
      S_CFG_FLAG: begin
        if (acc_done) begin
          state_nxt = S_CFG_ADDR;
        end
      end
      S_CFG_ADDR: begin
        if (acc_done) begin
          state_nxt = S_FINISH;
        end
      end
      S_SAVE: begin
        if (acc_done && last_word) begin
          state_nxt = S_LOAD;
        end
      end
      S_LOAD: begin
        if (acc_done && last_word) begin
          state_nxt = S_FINISH;
          ld_handler = !is_task_r;
        end
      end
      S_FINISH: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctx_idx_r <= 3'h0;
      vflag_r <= cid_pkg::REG_RST;
      handler_r <= cid_pkg::REG_RST;
      int_start <= '0;
    end else begin
      int_start <= {(state_r == S_CHECK) && (state_nxt == S_INT_RUN), id_r};
      if ((state_r == S_SAVE || state_r == S_LOAD) && acc_done) begin
        ctx_idx_r <= last_word ? 3'h0 : ctx_idx_r + 3'h1;
      end
      if (state_r == S_VEC_FLAG && acc_done) begin
        vflag_r <= mem_rdata;
      end
      if (state_r == S_VEC_ADDR && acc_done) begin
        handler_r <= mem_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // memory master
  assign mem_st = (state_r == S_VEC_FLAG) || (state_r == S_VEC_ADDR) ||
    (state_r == S_CFG_FLAG) || (state_r == S_CFG_ADDR) ||
    (state_r == S_SAVE) || (state_r == S_LOAD);
  assign acc_done = mem_req.valid && mem_ack;
  assign vec_a = cid_pkg::VEC_BASE + 32'(id_r) * cid_pkg::VEC_STRIDE;
  assign cfg_a = cid_pkg::VEC_BASE + gp1_r * cid_pkg::VEC_STRIDE;
  assign sv_base = is_task_r ? btp_r : ctp_r;
  assign ld_base = is_task_r ? ctp_r : btp_r;

  always_comb begin
    case (ctx_idx_r)
      3'h0: ctx_out = ip_r;
      3'h1: ctx_out = status_r;
      3'h2: ctx_out = gp1_r;
      3'h3: ctx_out = gp2_r;
      default: ctx_out = gp3_r;
    endcase
  end

  always_comb begin
    mem_addr_c = 32'h0;
    wdata_c = 32'h0;
    wr_c = 1'b0;
    case (state_r)
      S_VEC_FLAG: mem_addr_c = vec_a;
      S_VEC_ADDR: mem_addr_c = vec_a + cid_pkg::VEC_ADDR_OFS;
      S_CFG_FLAG: begin
        mem_addr_c = cfg_a;
        wdata_c = gp2_r;
        wr_c = 1'b1;
      end
      S_CFG_ADDR: begin
        mem_addr_c = cfg_a + cid_pkg::VEC_ADDR_OFS;
        wdata_c = gp3_r;
        wr_c = 1'b1;
      end
      S_SAVE: begin
        mem_addr_c = sv_base + 32'(ctx_idx_r) * cid_pkg::WORD_BYTES;
        wdata_c = ctx_out;
        wr_c = 1'b1;
      end
      S_LOAD: mem_addr_c = ld_base + 32'(ctx_idx_r) * cid_pkg::WORD_BYTES;
      default: mem_addr_c = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= '0;
    end else if (acc_done) begin
      mem_req.valid <= 1'b0;
    end else if (mem_st && !mem_req.valid) begin
      mem_req <= {1'b1, wr_c, mem_addr_c, wdata_c};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_task_denied;
    state_r == S_CHECK && is_task_r && priv_r;
  endsequence

  sequence s_vec_fetched;
    state_r == S_VEC_ADDR && acc_done && !is_hw_r;
  endsequence

  chk_task_priv: assert property (
    s_task_denied |=> fault_r[0] ##1 idle && !mem_req.valid)
    else $error("task load at level 1 did not fault");

  chk_task_off: assert property (
    state_r == S_CHECK && is_task_r && !priv_r && !status_r[2]
    |=> !mem_req.valid [*2])
    else $error("task load ran with switching disabled");

  chk_task_save: assert property (
    state_r == S_SAVE && is_task_r && mem_req.valid
    |-> mem_req.write && mem_req.addr == btp_r + 32'(ctx_idx_r) * cid_pkg::WORD_BYTES)
    else $error("task load saved to wrong pointer");

  chk_int_save: assert property (
    state_r == S_SAVE && !is_task_r && mem_req.valid && ctx_idx_r == 3'h0
    |-> mem_req.addr == ctp_r && mem_req.wdata == ip_r)
    else $error("interrupt saved to wrong pointer");

  chk_ip_hold: assert property (
    state_r inside {S_CHECK, S_VEC_FLAG, S_CFG_FLAG, S_INT_RUN}
    |=> $stable(ip_r))
    else $error("ip moved during validation");

  chk_hw_wait: assert property (
    idle && instr_active && !cmd_go |=> idle)
    else $error("hardware interrupt taken mid instruction");

  chk_vec_addr: assert property (
    state_r == S_VEC_FLAG && mem_req.valid
    |-> !mem_req.write && mem_req.addr == {22'h0, id_r, 3'h0})
    else $error("vector entry fetched from wrong address");

  chk_cfg_perm: assert property (
    state_r == S_CHECK && !is_hw_r && !is_task_r && id_r == 7'h01 && priv_r
    |=> fault_r[1] && fault_r[13] && fault_r[31:24] == 8'h01)
    else $error("vector config at level 1 did not fault");

  chk_cfg_write: assert property (
    state_r == S_CFG_FLAG && acc_done
    |-> mem_req.write && mem_req.wdata == gp2_r
    ##2 mem_req.valid && mem_req.wdata == gp3_r)
    else $error("vector config wrote wrong words");

  chk_lvl1_deny: assert property (
    s_vec_fetched ##0 priv_r && !vflag_r[0] && (vflag_r != 32'h0 || mem_rdata != 32'h0)
    |=> fault_r[0] && fault_r[13] ##1 idle)
    else $error("level 1 reached a level 0 handler");

  chk_nontrap: assert property (
    state_r == S_INT_RUN && int_done && !trap |=> state_r == S_FINISH)
    else $error("non-trappable interrupt read its entry");
endmodule // cid_dispatch
`default_nettype wire

// ---- tb/cid_dev_model.sv ----
// memory and internal routine model on the engine's far side
`timescale 1ns/1ps
`default_nettype none
module cid_dev_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // memory port
  input wire cid_pkg::cid_mem_req_t mem_req,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // internal routine
  input wire cid_pkg::cid_int_evt_t int_start,
  output logic int_done,
  // traffic count
  output logic [15:0] acc_cnt
);
  logic [31:0] mem [0:4095];
  logic [31:0] last_r;
  logic [1:0] wait_r;
  logic [1:0] rt_r;
  logic slow_r;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 32'h0;
  end
  ////////////////////////////////////////////////////////////////
  // prompt and slow answers alternate
  assign mem_ack = mem_req.valid && (wait_r == (slow_r ? 2'h2 : 2'h0));
  assign mem_rdata = mem_ack ? mem[mem_req.addr[13:2]] : ~last_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_r <= 2'h0;
      slow_r <= 1'b0;
      acc_cnt <= 16'h0;
      last_r <= 32'h0;
    end else if (mem_ack) begin
      acc_cnt <= acc_cnt + 16'h1;
      slow_r <= !slow_r;
      wait_r <= 2'h0;
      last_r <= mem_rdata;
      if (mem_req.write) mem[mem_req.addr[13:2]] <= mem_req.wdata;
    end else if (mem_req.valid) begin
      wait_r <= wait_r + 2'h1;
    end
  end
  // routine ends a few cycles after start
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rt_r <= 2'h0;
    else if (int_start.valid) rt_r <= 2'h3;
    else if (rt_r != 2'h0) rt_r <= rt_r - 2'h1;
  end
  assign int_done = (rt_r == 2'h1);
endmodule // cid_dev_model
`default_nettype wire

// ---- tb/cid_dispatch_tb_top.sv ----
// self-checking bench for the interrupt dispatch engine
`timescale 1ns/1ps
`default_nettype none
module cid_dispatch_tb_top;
  logic hclk, hresetn, hsel, hwrite, instr_active, hw_irq_req;
  logic hreadyout, hresp, mem_ack, int_done;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata, r;
  logic [1:0] htrans;
  logic [6:0] hw_irq_id, int_id;
  logic [15:0] acc_cnt;
  cid_pkg::cid_mem_req_t mem_req;
  cid_pkg::cid_int_evt_t int_start;
  int miscompares, total_checks, cyc, n_int;
  cid_dispatch i_cid_dispatch (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(cid_pkg::HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .instr_active(instr_active), .hw_irq_req(hw_irq_req), .hw_irq_id(hw_irq_id),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .int_start(int_start),
    .int_done(int_done));
  cid_dev_model i_cid_dev_model (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .int_start(int_start), .int_done(int_done),
    .acc_cnt(acc_cnt));
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (int_start.valid) begin
      n_int <= n_int + 1;
      int_id <= int_start.id;
    end
    if (mem_ack && !mem_req.write && mem_req.addr == 32'h48 && n_int == 0) begin
      fail("early fetch");
    end
    if (cyc == 20000) begin
      fail("timeout");
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic fail(input string m);
    miscompares++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) fail($sformatf("got %h exp %h", g, e));
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    if (hresp !== 1'b0) fail("error response");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, cid_pkg::A_STATE, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 300);
    if (n >= 300) fail("engine hang");
  endtask
  task automatic cmd(input logic [1:0] op, input logic [6:0] id);
    wr(cid_pkg::A_CMD, {22'h0, op, 1'b0, id});
    idle();
  endtask
  task automatic cfg(input logic [6:0] id, input logic [31:0] f, input logic [31:0] a);
    wr(cid_pkg::A_GP1, {25'h0, id});
    wr(cid_pkg::A_GP2, f);
    wr(cid_pkg::A_GP3, a);
    cmd(cid_pkg::OP_SOFT_INT, cid_pkg::ID_VEC_CFG);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_reset();
    rd(cid_pkg::A_STATUS, cid_pkg::REG_RST);
    rd(cid_pkg::A_FAULT, cid_pkg::REG_RST);
    rd(8'h40, 32'h0);
  endtask
  task automatic s_task();
    logic [31:0] a;
    wr(cid_pkg::A_PRIV, 32'h1);
    cmd(cid_pkg::OP_TASK_LOAD, 7'h0);
    rd(cid_pkg::A_FAULT, cid_pkg::FF_PRIV_M);
    wr(cid_pkg::A_FAULT, 32'h0);
    wr(cid_pkg::A_PRIV, 32'h0);
    a = {16'h0, acc_cnt};
    cmd(cid_pkg::OP_TASK_LOAD, 7'h0);
    chk({16'h0, acc_cnt}, a);
    wr(cid_pkg::A_STATUS, 32'h4);
    wr(cid_pkg::A_CTP, 32'h1000);
    wr(cid_pkg::A_BTP, 32'h2000);
    wr(cid_pkg::A_GP1, 32'h11);
    i_cid_dev_model.mem[12'h401] = 32'h4;
    i_cid_dev_model.mem[12'h402] = 32'h22;
    cmd(cid_pkg::OP_TASK_LOAD, 7'h0);
    chk(i_cid_dev_model.mem[12'h802], 32'h11);
    rd(cid_pkg::A_GP1, 32'h22);
  endtask
  task automatic s_cfg();
    logic [6:0] bad [2];
    bad = '{7'h7f, 7'h03};
    cfg(7'h30, 32'h1, 32'h4000);
    chk(i_cid_dev_model.mem[12'h060], 32'h1);
    chk(i_cid_dev_model.mem[12'h061], 32'h4000);
    for (int i = 0; i < 2; i++) begin
      cfg(bad[i], 32'h1, 32'h1);
      rd(cid_pkg::A_FAULT, cid_pkg::FF_BADV_M | cid_pkg::FF_SOFT_INTERRUPT_INSTR_M | 32'h0100_0000);
      wr(cid_pkg::A_FAULT, 32'h0);
    end
    wr(cid_pkg::A_PRIV, 32'h1);
    cfg(7'h30, 32'h1, 32'h4000);
    rd(cid_pkg::A_FAULT, cid_pkg::FF_PERM_M | cid_pkg::FF_SOFT_INTERRUPT_INSTR_M | 32'h0100_0000);
    wr(cid_pkg::A_PRIV, 32'h0);
    wr(cid_pkg::A_FAULT, 32'h0);
  endtask
  task automatic s_soft();
    wr(cid_pkg::A_GP1, 32'h33);
    wr(cid_pkg::A_STATUS, 32'h4);
    cmd(cid_pkg::OP_SOFT_INT, 7'h30);
    rd(cid_pkg::A_IP, 32'h4000);
    chk(i_cid_dev_model.mem[12'h402], 32'h33);
    rd(cid_pkg::A_GP1, 32'h11);
  endtask
  task automatic s_priv();
    wr(cid_pkg::A_STATUS, 32'h0);
    cfg(7'h31, 32'h0, 32'h5000);
    wr(cid_pkg::A_PRIV, 32'h1);
    wr(cid_pkg::A_IP, 32'h700);
    cmd(cid_pkg::OP_SOFT_INT, 7'h31);
    rd(cid_pkg::A_FAULT, cid_pkg::FF_PRIV_M | cid_pkg::FF_SOFT_INTERRUPT_INSTR_M | 32'h3100_0000);
    rd(cid_pkg::A_IP, 32'h700);
    wr(cid_pkg::A_PRIV, 32'h0);
    wr(cid_pkg::A_FAULT, 32'h0);
    cfg(7'h30, 32'h0, 32'h0);
    cmd(cid_pkg::OP_SOFT_INT, 7'h30);
    rd(cid_pkg::A_IP, 32'h700);
  endtask
  task automatic s_hw();
    logic [15:0] a;
    cfg(cid_pkg::ID_KBD, 32'h1, 32'h6000);
    wr(cid_pkg::A_STATUS, 32'h1);
    instr_active <= 1'b1;
    hw_irq_id <= cid_pkg::ID_KBD;
    repeat (5) @(posedge hclk);
    hw_irq_req <= 1'b1;
    repeat (12) @(posedge hclk);
    chk(n_int, 32'h0);
    instr_active <= 1'b0;
    repeat (3) @(posedge hclk);
    idle();
    hw_irq_req <= 1'b0;
    chk(n_int, 32'h1);
    chk({25'h0, int_id}, {25'h0, cid_pkg::ID_KBD});
    rd(cid_pkg::A_IP, 32'h6000);
    a = acc_cnt;
    cmd(cid_pkg::OP_SOFT_INT, 7'h0a);
    chk({16'h0, acc_cnt}, {16'h0, a});
    chk(n_int, 32'h2);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, instr_active, hw_irq_req} = 4'h0;
    {haddr, hwdata, htrans, hw_irq_id} = '0;
    {miscompares, total_checks, cyc, n_int} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_task();
    s_cfg();
    s_soft();
    s_priv();
    s_hw();
    print_verdict();
  end
endmodule // cid_dispatch_tb_top
`default_nettype wire
